/* File: rtl/clb_bus_unit.sv */
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// data queue
// ----------------------------------------
module clb_fifo #(
  parameter int W = 32,
  parameter int D = 4
) (
  input  wire logic         clk_sys,
  input  wire logic         reset,
  input  wire logic         ce,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int PW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);

  typedef struct packed {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
  } clb_fifo_t;

  clb_fifo_t        s;
  clb_fifo_t        next_s;
  logic [W-1:0]     mem [D];
  logic             push;
  logic             pop;

  assign in_ready  = (s.cnt != CW'(D));
  assign out_valid = (s.cnt != '0);
  assign out_data  = mem[s.rp];
  assign push      = ce & in_valid & in_ready;
  assign pop       = ce & out_valid & out_ready;

  always_comb begin
    next_s = s;
    if (push) begin
      next_s.wp = (s.wp == PW'(D - 1)) ? '0 : s.wp + 1'b1;
    end
    if (pop) begin
      next_s.rp = (s.rp == PW'(D - 1)) ? '0 : s.rp + 1'b1;
    end
    next_s.cnt = s.cnt + CW'(push) - CW'(pop);
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
    if (push) begin
      mem[s.wp] <= in_data;
    end
  end
endmodule

// ----------------------------------------
// local bus unit
// ----------------------------------------
module clb_bus_unit #(
  parameter int DEPTH = clb_pkg::FIFO_DEPTH
) (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        ce,
  // core request side
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic        req_write,
  input  wire logic        req_mio,
  input  wire logic        req_dc,
  input  wire logic        req_lock,
  input  wire logic [1:0]  req_be_n,
  input  wire logic [15:0] req_seg,
  input  wire logic [15:0] req_ofs,
  input  wire logic [23:0] req_phys,
  input  wire logic [15:0] req_wdata,
  output logic             wr_done,
  output logic             rd_valid,
  input  wire logic        rd_ready,
  output logic      [31:0] rd_data,
  input  wire logic        set_protected,
  output logic             protected_mode,
  output logic             core_init,
  output logic             maskable_irq_sampled,
  output logic             nmi_pending,
  input  wire logic        nmi_ack,
  output logic             exec_stall,
  output logic             copro_xfer_req,
  output logic             copro_error,
  // local bus pins
  input  wire logic [15:0] data_lines_in,
  output logic      [15:0] data_lines_out,
  output logic             data_lines_oe,
  output logic      [22:0] word_address_lines,
  output logic             high_byte_enable_n,
  output logic             low_byte_enable_n,
  output logic             address_strobe_n,
  output logic             mem_io_sel,
  output logic             data_ctrl,
  output logic             write_read,
  output logic             lock_n,
  output logic             bus_oe,
  input  wire logic        transfer_ack_n,
  input  wire logic        next_address_n,
  input  wire logic        bus_request,
  output logic             bus_grant,
  input  wire logic        maskable_irq,
  input  wire logic        nmi,
  input  wire logic        copro_operand_request,
  input  wire logic        copro_busy_n,
  input  wire logic        copro_error_n
);
  typedef struct packed {
    clb_pkg::clb_state_t st;
    logic                ph;
    clb_pkg::clb_cyc_t   pins;
    clb_pkg::clb_cyc_t   cur;
    logic                pipe_v;
    logic                ads_n;
    logic                half_v;
    logic [15:0]         half;
    logic                done;
    logic                init;
    logic                prot;
    logic                maskable_irq_q;
    logic                nmi_prev;
    logic                nmi_pend;
    logic                busy_q;
    logic                err_q;
    logic                copro_operand_request_q;
  } clb_bus_t;

  localparam clb_pkg::clb_cyc_t CYC_RST = '{
    addr: clb_pkg::ADDR_RST, be_n: clb_pkg::BE_NONE_N, mio: 1'b0,
    dc: 1'b0, wr: 1'b0, lock: 1'b0, wdata: clb_pkg::DATA_RST};

  clb_bus_t                    s;
  clb_bus_t                    next_s;
  clb_pkg::clb_cyc_t           cyc_in;
  logic                        pcyc;
  logic [clb_pkg::REAL_AW-1:0] real_a;
  logic [23:0]                 phys;
  logic                        q_in_valid;
  logic                        q_in_ready;
  logic [31:0]                 q_in_data;
  logic                        can_take;
  logic                        pipe_ok;

  // ----------------------------------------
  // address formation
  // ----------------------------------------
  assign pcyc   = ce & s.ph;
  assign real_a = {req_seg, 4'h0} + {4'h0, req_ofs};
  assign phys   = s.prot ? req_phys : {4'h0, real_a};

  always_comb begin
    cyc_in.addr  = phys[23:1];
    cyc_in.be_n  = req_be_n;
    cyc_in.mio   = req_mio;
    cyc_in.dc    = req_dc;
    cyc_in.wr    = req_write;
    cyc_in.lock  = req_lock;
    cyc_in.wdata = req_wdata;
  end

  // reads only start with queue room, so a finished read never overflows it
  assign can_take = req_valid & (req_write | q_in_ready);
  // early issue limited to writes: keeps at most one read outstanding
  assign pipe_ok  = (s.st == clb_pkg::ST_WAIT) & ~next_address_n & ~s.pipe_v
                  & req_valid & req_write & transfer_ack_n;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_s     = s;
    req_ready  = 1'b0;
    q_in_valid = 1'b0;
    q_in_data  = {data_lines_in, s.half};
    if (ce) begin
      next_s.ph = ~s.ph;
    end
    if (pcyc) begin
      next_s.done     = 1'b0;
      next_s.init     = 1'b0;
      next_s.maskable_irq_q   = maskable_irq;
      next_s.busy_q   = ~copro_busy_n;
      next_s.err_q    = ~copro_error_n;
      next_s.copro_operand_request_q  = copro_operand_request;
      next_s.nmi_prev = nmi;
      next_s.nmi_pend = (s.nmi_pend & ~nmi_ack) | (nmi & ~s.nmi_prev);
      if (set_protected) begin
        next_s.prot = 1'b1;
      end
      case (s.st)
        clb_pkg::ST_IDLE: begin
          if (bus_request & ~s.pins.lock) begin
            next_s.st = clb_pkg::ST_HOLD;
          end else if (can_take) begin
            req_ready    = 1'b1;
            next_s.pins  = cyc_in;
            next_s.cur   = cyc_in;
            next_s.ads_n = 1'b0;
            next_s.st    = clb_pkg::ST_ADDR;
          end
        end
        clb_pkg::ST_ADDR: begin
          next_s.ads_n = 1'b1;
          next_s.st    = clb_pkg::ST_WAIT;
        end
        clb_pkg::ST_WAIT: begin
          next_s.ads_n = 1'b1;
          if (~transfer_ack_n) begin
            if (s.cur.wr) begin
              next_s.done = 1'b1;
            end else if (s.half_v) begin
              q_in_valid    = 1'b1;
              next_s.half_v = 1'b0;
            end else begin
              next_s.half   = data_lines_in;
              next_s.half_v = 1'b1;
            end
            if (s.pipe_v) begin
              next_s.cur    = s.pins;
              next_s.pipe_v = 1'b0;
            end else begin
              next_s.st = clb_pkg::ST_IDLE;
            end
          end else if (pipe_ok) begin
            req_ready     = 1'b1;
            next_s.pins   = cyc_in;
            next_s.pipe_v = 1'b1;
            next_s.ads_n  = 1'b0;
          end
        end
        clb_pkg::ST_HOLD: begin
          if (~bus_request) begin
            next_s.st = clb_pkg::ST_IDLE;
          end
        end
        default: begin
          next_s.st = clb_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s          <= '0;
      s.st       <= clb_pkg::ST_IDLE;
      s.pins     <= CYC_RST;
      s.cur      <= CYC_RST;
      s.ads_n    <= 1'b1;
      s.init     <= 1'b1;
      s.prot     <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // prefetch and read queue
  // ----------------------------------------
  clb_fifo #(
    .W (clb_pkg::FIFO_W),
    .D (DEPTH)
  ) u_queue (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .ce        (ce),
    .in_valid  (q_in_valid),
    .in_ready  (q_in_ready),
    .in_data   (q_in_data),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_data)
  );

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign bus_grant          = (s.st == clb_pkg::ST_HOLD);
  assign bus_oe             = ~bus_grant;
  assign word_address_lines = s.pins.addr;
  assign high_byte_enable_n = s.pins.be_n[1];
  assign low_byte_enable_n  = s.pins.be_n[0];
  assign mem_io_sel         = s.pins.mio;
  assign data_ctrl          = s.pins.dc;
  assign write_read         = s.pins.wr;
  assign lock_n             = ~s.pins.lock;
  assign address_strobe_n   = s.ads_n;
  assign data_lines_out     = s.cur.wdata;
  assign data_lines_oe      = s.cur.wr & (s.st == clb_pkg::ST_ADDR | s.st == clb_pkg::ST_WAIT);
  assign wr_done            = s.done;
  assign protected_mode     = s.prot;
  assign core_init          = s.init;
  assign maskable_irq_sampled       = s.maskable_irq_q;
  assign nmi_pending        = s.nmi_pend;
  assign exec_stall         = s.busy_q;
  assign copro_xfer_req     = s.copro_operand_request_q;
  assign copro_error        = s.err_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_ack_last;
    pcyc && s.st == clb_pkg::ST_WAIT && !transfer_ack_n && !s.pipe_v;
  endsequence

  a_clk_halved: assert property (ce |=> s.ph != $past(s.ph))
    else $error("phase did not toggle");
  a_write_drive: assert property (data_lines_oe |-> write_read && bus_oe)
    else $error("data driven outside a write");
  a_strobe_valid: assert property (!address_strobe_n |-> bus_oe && s.st != clb_pkg::ST_IDLE)
    else $error("strobe without a live cycle");
  a_ack_ends: assert property (s_ack_last |=> s.st == clb_pkg::ST_IDLE)
    else $error("cycle not ended by acknowledge");
  a_grant_float: assert property (bus_grant |-> !bus_oe && !data_lines_oe)
    else $error("bus driven while granted");
  a_lock_grant: assert property ($rose(bus_grant) |-> $past(lock_n))
    else $error("grant inside a locked sequence");
  a_maskable_irq_sample: assert property (pcyc |=> maskable_irq_sampled == $past(maskable_irq))
    else $error("interrupt request not sampled");
  a_nmi_latch: assert property (pcyc && nmi && !s.nmi_prev |=> nmi_pending)
    else $error("nmi edge lost");
  a_busy_stall: assert property (pcyc && !copro_busy_n |=> exec_stall)
    else $error("busy did not stall");
  a_reset_real: assert property ($fell(reset) |-> !protected_mode && core_init)
    else $error("not in real mode after reset");
  a_real_addr: assert property (req_ready && !s.prot && s.st == clb_pkg::ST_IDLE
    |=> word_address_lines == $past(real_a[19:1]))
    else $error("real address wrong");
  a_addr_stable: assert property (s.st == clb_pkg::ST_WAIT && $past(s.st) == clb_pkg::ST_WAIT
    && address_strobe_n && $past(address_strobe_n) |-> $stable(word_address_lines))
    else $error("address moved during cycle");
endmodule
`default_nettype wire

/* File: rtl/clb_pkg.sv */
package clb_pkg;
  // ----------------------------------------
  // bus widths and address formation
  // ----------------------------------------
  localparam int          DATA_W      = 16;
  localparam int          ADDR_W      = 24;
  localparam int          REAL_AW     = 20;
  localparam int          SEG_SHIFT   = 4;
  localparam int          QUEUE_BYTES = 16;
  localparam int          FIFO_W      = 32;
  localparam int          FIFO_DEPTH  = QUEUE_BYTES / (FIFO_W / 8);
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [1:0]  BE_NONE_N   = 2'h3;
  localparam logic [22:0] ADDR_RST    = 23'h000000;
  localparam logic [15:0] DATA_RST    = 16'h0000;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ADDR = 4'h2,
    ST_WAIT = 4'h4,
    ST_HOLD = 4'h8
  } clb_state_t;

  typedef struct packed {
    logic [22:0] addr;
    logic [1:0]  be_n;
    logic        mio;
    logic        dc;
    logic        wr;
    logic        lock;
    logic [15:0] wdata;
  } clb_cyc_t;
endpackage

/* File: dv/clb_sys_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// system interface partner
// ----------------------------------------
module clb_sys_model (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        address_strobe_n,
  input  wire logic [22:0] word_address_lines,
  input  wire logic [2:0]  wait_states,
  output logic             transfer_ack_n,
  output logic      [15:0] data_lines_in
);
  logic       strobe_q;
  logic       pend;
  logic [4:0] cnt;
  logic [15:0] rdata;

  // count starts on a strobe fall; an early strobe waits as pend until the current count ends
  always_ff @(posedge clk_sys) begin
    strobe_q <= address_strobe_n;
    if (reset) begin
      cnt  <= 5'h00;
      pend <= 1'b0;
    end else if (strobe_q && !address_strobe_n && cnt == 5'h00) begin
      cnt <= 5'h04 + {1'b0, wait_states, 1'b0};
    end else begin
      if (strobe_q && !address_strobe_n) begin
        pend <= 1'b1;
      end
      if (cnt == 5'h01 && pend) begin
        cnt  <= 5'h04 + {1'b0, wait_states, 1'b0};
        pend <= 1'b0;
      end else if (cnt != 5'h00) begin
        cnt <= cnt - 5'h01;
      end
    end
  end

  // two clocks wide, so exactly one processing edge sees it
  assign transfer_ack_n = !(cnt == 5'h02 || cnt == 5'h01);
  assign rdata = word_address_lines[15:0] ^ 16'ha5a5;
  // off the ack window the lines show garbage, not stale data
  assign data_lines_in = transfer_ack_n ? ~rdata : rdata;
endmodule
`default_nettype wire

/* File: dv/clb_bus_unit_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module clb_bus_unit_tb;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic        req_valid = 1'b0, req_write = 1'b0, req_mio = 1'b0, req_dc = 1'b0, req_lock = 1'b0;
  logic        rd_ready = 1'b1, set_protected = 1'b0, nmi_ack = 1'b0, bus_request = 1'b0;
  logic        maskable_irq = 1'b0, nmi = 1'b0, copro_operand_request = 1'b0;
  logic        copro_busy_n = 1'b1, copro_error_n = 1'b1;
  logic [1:0]  req_be_n = 2'h3;
  logic [15:0] req_seg = 16'h0000, req_ofs = 16'h0000, req_wdata = 16'h0000;
  logic [23:0] req_phys = 24'h000000;
  logic [2:0]  wait_states = 3'h0;
  logic        next_address_n = 1'b1;
  logic        req_ready, wr_done, rd_valid, protected_mode, core_init, maskable_irq_sampled, nmi_pending;
  logic        exec_stall, copro_xfer_req, copro_error, data_lines_oe, high_byte_enable_n;
  logic        low_byte_enable_n, address_strobe_n, mem_io_sel, data_ctrl, write_read, lock_n;
  logic        bus_oe, bus_grant, transfer_ack_n;
  logic [15:0] data_lines_in, data_lines_out;
  logic [22:0] word_address_lines;
  logic [31:0] rd_data;
  int          n_fail = 0, n_compared = 0, cycles = 0;

  always #2.5 clk_sys = ~clk_sys;

  clb_bus_unit clb_bus_unit_i (.clk_sys, .reset, .ce(1'b1), .req_valid, .req_ready, .req_write, .req_mio,
    .req_dc, .req_lock, .req_be_n, .req_seg, .req_ofs, .req_phys, .req_wdata, .wr_done, .rd_valid, .rd_ready,
    .rd_data, .set_protected, .protected_mode, .core_init, .maskable_irq_sampled, .nmi_pending, .nmi_ack, .exec_stall,
    .copro_xfer_req, .copro_error, .data_lines_in, .data_lines_out, .data_lines_oe, .word_address_lines,
    .high_byte_enable_n, .low_byte_enable_n, .address_strobe_n, .mem_io_sel, .data_ctrl, .write_read, .lock_n,
    .bus_oe, .transfer_ack_n, .next_address_n, .bus_request, .bus_grant, .maskable_irq, .nmi,
    .copro_operand_request, .copro_busy_n, .copro_error_n);

  clb_sys_model clb_sys_model_i (.clk_sys, .reset, .address_strobe_n, .word_address_lines, .wait_states,
    .transfer_ack_n, .data_lines_in);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic stop_test();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // drives one cycle and judges the pins; ctl is {lock, mem_io, data_ctrl}
  task automatic bus_cycle(input logic wr, input logic [2:0] ctl, input logic [1:0] be, input logic [15:0] seg,
                           input logic [15:0] ofs, input logic [23:0] pa, input logic [23:0] exp_pa);
    int          i;
    logic [22:0] a;
    req_write = wr;
    {req_lock, req_mio, req_dc} = ctl;
    req_be_n = be;
    req_seg = seg;
    req_ofs = ofs;
    req_phys = pa;
    req_wdata = ofs ^ 16'h3c3c;
    req_valid = 1'b1;
    i = 0;
    do begin @(negedge clk_sys); i++; end while (req_ready !== 1'b1 && i < 20);
    check(req_ready, 1'b1);
    cyc(1);
    req_valid = 1'b0;
    i = 0;
    while (address_strobe_n !== 1'b0 && i < 10) begin cyc(1); i++; end
    check(address_strobe_n, 1'b0);
    check(word_address_lines, exp_pa[23:1]);
    check({high_byte_enable_n, low_byte_enable_n}, be);
    check({lock_n, mem_io_sel, data_ctrl}, {~ctl[2], ctl[1:0]});
    check(write_read, wr);
    check(data_lines_oe, wr);
    if (wr)
      check(data_lines_out, ofs ^ 16'h3c3c);
    a = word_address_lines;
    i = 0;
    do begin
      cyc(1);
      i++;
      check(word_address_lines, a);
    end while (transfer_ack_n !== 1'b0 && i < 30);
    check(transfer_ack_n, 1'b0);
    if (wr) begin
      i = 0;
      while (wr_done !== 1'b1 && i < 8) begin cyc(1); i++; end
      check(wr_done, 1'b1);
    end
    cyc(2);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    check({address_strobe_n, high_byte_enable_n, low_byte_enable_n, lock_n, bus_grant, bus_oe}, 6'h3d);
    check({data_lines_oe, protected_mode, core_init}, 3'h1);
  endtask

  task automatic t_writes();
    wait_states = 3'h2;
    bus_cycle(1'b1, 3'h3, 2'h0, 16'h1234, 16'h0010, 24'h000000, 24'h012350);
    wait_states = 3'h0;
    bus_cycle(1'b1, 3'h0, 2'h1, 16'h0000, 16'h00f8, 24'h000000, 24'h0000f8);
    bus_cycle(1'b1, 3'h7, 2'h2, 16'hf000, 16'hfffe, 24'h000000, 24'h0ffffe);
    // lock still stands from the last cycle, so a hold request must wait
    bus_request = 1'b1;
    cyc(8);
    check(bus_grant, 1'b0);
    bus_request = 1'b0;
  endtask

  task automatic t_reads();
    int i;
    rd_ready = 1'b0;
    wait_states = 3'h1;
    bus_cycle(1'b0, 3'h3, 2'h0, 16'h8000, 16'hfffc, 24'h000000, 24'h08fffc);
    bus_cycle(1'b0, 3'h3, 2'h0, 16'h8000, 16'hfffe, 24'h000000, 24'h08fffe);
    i = 0;
    while (rd_valid !== 1'b1 && i < 8) begin cyc(1); i++; end
    check(rd_valid, 1'b1);
    check(rd_data, {16'h7fff ^ 16'ha5a5, 16'h7ffe ^ 16'ha5a5});
    rd_ready = 1'b1;
    cyc(2);
    check(rd_valid, 1'b0);
  endtask

  task automatic t_pipeline();
    int i;
    wait_states = 3'h1;
    next_address_n = 1'b0;
    req_write = 1'b1;
    {req_lock, req_mio, req_dc} = 3'h3;
    req_be_n = 2'h0;
    req_seg = 16'h0000;
    req_ofs = 16'h0100;
    req_wdata = 16'h1111;
    req_valid = 1'b1;
    i = 0;
    do begin @(negedge clk_sys); i++; end while (req_ready !== 1'b1 && i < 20);
    cyc(1);
    // second write offered at once: it can only go out before the first is acknowledged
    req_ofs = 16'h0200;
    req_wdata = 16'h2222;
    i = 0;
    do begin @(negedge clk_sys); i++; end while (req_ready !== 1'b1 && i < 20);
    check(transfer_ack_n, 1'b1);
    cyc(1);
    req_valid = 1'b0;
    check(address_strobe_n, 1'b0);
    check(word_address_lines, 23'h000100);
    check(data_lines_out, 16'h1111);
    i = 0;
    while (wr_done !== 1'b1 && i < 30) begin cyc(1); i++; end
    check(wr_done, 1'b1);
    check(data_lines_out, 16'h2222);
    cyc(2);
    i = 0;
    while (wr_done !== 1'b1 && i < 30) begin cyc(1); i++; end
    check(wr_done, 1'b1);
    next_address_n = 1'b1;
    cyc(2);
  endtask

  task automatic t_hold();
    bus_request = 1'b1;
    cyc(8);
    check({bus_grant, bus_oe}, 2'h2);
    bus_request = 1'b0;
    cyc(8);
    check({bus_grant, bus_oe}, 2'h1);
  endtask

  task automatic t_side_inputs();
    maskable_irq = 1'b1;
    copro_busy_n = 1'b0;
    copro_error_n = 1'b0;
    copro_operand_request = 1'b1;
    nmi = 1'b1;
    cyc(4);
    check({maskable_irq_sampled, exec_stall, copro_error, copro_xfer_req, nmi_pending}, 5'h1f);
    maskable_irq = 1'b0;
    copro_busy_n = 1'b1;
    copro_error_n = 1'b1;
    copro_operand_request = 1'b0;
    nmi_ack = 1'b1;
    cyc(4);
    nmi_ack = 1'b0;
    // nmi still high: a level must not set it again
    cyc(4);
    check({maskable_irq_sampled, exec_stall, copro_error, copro_xfer_req, nmi_pending}, 5'h00);
    nmi = 1'b0;
  endtask

  task automatic t_protected();
    set_protected = 1'b1;
    cyc(4);
    set_protected = 1'b0;
    check(protected_mode, 1'b1);
    bus_cycle(1'b1, 3'h3, 2'h0, 16'h1234, 16'h0010, 24'hc0fff0, 24'hc0fff0);
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      stop_test();
    end
  end

  initial begin
    cyc(16);
    t_reset();
    reset = 1'b0;
    t_writes();
    t_reads();
    t_pipeline();
    t_hold();
    t_side_inputs();
    t_protected();
    stop_test();
  end
endmodule
`default_nettype wire
